// File: design/ttgm_pkg.sv
// Package: shared types and constants of the event gating and marker block
package ttgm_pkg;

    localparam int unsigned CHAN_W          = 4;
    localparam int unsigned TIME_W          = 12;
    localparam int unsigned NSYNC_W         = 16;
    localparam int unsigned NUM_MARKERS     = 3;
    localparam int unsigned REC_W           = 32;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned FIFO_AW         = 4;
    // Documented record capacity of the downstream record buffer
    localparam int unsigned REC_BUF_RECORDS = 262144;
    localparam int unsigned BASE_RES_PS     = 4;
    localparam int unsigned MAX_BIN_PS      = 512;
    localparam int unsigned HIST_BINS       = 65536;
    localparam int unsigned BIN_SEL_W       = 3;
    localparam logic [2:0]  BIN_SEL_MAX     = 3'h7;
    localparam int unsigned SYNC_DIV        = 8;
    localparam int unsigned SYNC_DIV_W      = 3;
    localparam logic [3:0]  CHAN_SPECIAL    = 4'hf;
    localparam logic [11:0] TIME_OVERFLOW   = 12'h000;
    localparam logic [15:0] NSYNC_RST       = 16'h0000;

    typedef enum logic [1:0] {
        TTGM_MODE_HIST,
        TTGM_MODE_ABS_TAG,
        TTGM_MODE_SYNC_REL_TAG
    } ttgm_mode_t;

    typedef struct packed {
        logic [3:0]  chan;
        logic [11:0] dtime;
        logic [15:0] nsync;
    } ttgm_rec_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  chan;
        logic [11:0] dtime;
    } ttgm_photon_t;

endpackage

// File: design/ttgm_fifo.sv
// Small record FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ttgm_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic [WIDTH-1:0] dout_r;
    logic             dval_r;

    wire logic full    = (cnt_r == (AW+1)'(DEPTH));
    wire logic empty   = (cnt_r == '0);
    // Output register refills when empty or being consumed
    wire logic load    = !empty && (!dval_r || out_ready);
    wire logic wr      = in_valid && !full;

    assign in_ready  = !full;
    assign out_valid = dval_r;
    assign out_data  = dout_r;

    always_ff @(posedge clk) begin
        if (ce && wr) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r   <= '0;
            rp_r   <= '0;
            cnt_r  <= '0;
            dout_r <= '0;
            dval_r <= 1'b0;
        end else if (ce) begin
            if (wr) begin
                wp_r <= wp_r + 1'b1;
            end
            if (load) begin
                dout_r <= mem[rp_r];
                rp_r   <= rp_r + 1'b1;
                dval_r <= 1'b1;
            end else if (out_ready) begin
                dval_r <= 1'b0;
            end
            cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(load);
        end
    end
endmodule
`default_nettype wire

// File: design/ttgm_top.sv
// Top: count gating, marker capture and record arbitration
`timescale 1ns/1ps
`default_nettype none
module ttgm_top
    import ttgm_pkg::*;
(
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST,
    input  wire logic                    CE,
    input  wire ttgm_pkg::ttgm_mode_t    MODE,
    input  wire logic                    MEAS_START,
    input  wire logic                    MEAS_STOP,
    input  wire logic                    MARKER_FALLING,
    input  wire logic [2:0]              BIN_SEL,
    input  wire logic                    SYNC_DIV_EN,
    input  wire logic                    SYNC_IN,
    input  wire logic                    COUNT_ENABLE,
    input  wire logic [2:0]              MARKER_IN,
    input  wire ttgm_pkg::ttgm_photon_t  PHOTON,
    output logic                         REC_VALID,
    input  wire logic                    REC_READY,
    output ttgm_pkg::ttgm_rec_t          REC_DATA,
    output logic                         MEAS_ACTIVE,
    output logic                         PHOTON_DROP,
    output logic                         HIST_VALID,
    output logic [15:0]                  HIST_BIN,
    output logic                         BIN_SEL_ERR
);
    import ttgm_pkg::*;

    logic        en_s1_r;
    logic        en_s2_r;
    logic [2:0]  mk_s1_r;
    logic [2:0]  mk_s2_r;
    logic [2:0]  mk_s3_r;
    logic        sync_s1_r;
    logic        sync_s2_r;
    logic        sync_s3_r;
    logic [2:0]  div_r;
    logic [15:0] nsync_r;
    logic        active_r;
    logic        rec_val_r;
    ttgm_rec_t   rec_r;
    logic        drop_r;
    logic        hist_val_r;
    logic [15:0] hist_bin_r;
    logic        bin_err_r;
    logic [2:0]  mk_pend_r;
    logic        ovf_pend_r;
    logic        out_valid;
    ttgm_rec_t   out_data;
    logic        fifo_ready;
    logic [2:0]  mk_pend_nxt;

    // Pads are pulled: COUNT_ENABLE defaults high, markers default low, so open pins stay benign
    wire logic       tag_mode   = (MODE == TTGM_MODE_ABS_TAG) || (MODE == TTGM_MODE_SYNC_REL_TAG);
    wire logic       gate_open  = en_s2_r;
    wire logic       photon_ok  = PHOTON.valid && gate_open && active_r;
    wire logic [2:0] mk_edge    = MARKER_FALLING ? (mk_s3_r & ~mk_s2_r) : (mk_s2_r & ~mk_s3_r);
    wire logic [2:0] mk_new     = (tag_mode && active_r) ? mk_edge : 3'h0;
    wire logic [2:0] mk_all     = mk_pend_r | mk_new;
    wire logic       sync_edge  = sync_s2_r && !sync_s3_r;
    wire logic       sync_tick  = sync_edge && (!SYNC_DIV_EN || (div_r == 3'(SYNC_DIV - 1)));
    wire logic       nsync_wrap = sync_tick && (nsync_r == 16'hffff);
    wire logic       send_mk    = (mk_all != 3'h0) && fifo_ready;
    wire logic       send_ovf   = !send_mk && (ovf_pend_r || nsync_wrap) && fifo_ready;
    wire logic       send_ph    = photon_ok && tag_mode && fifo_ready && !send_mk && !send_ovf;
    wire logic       lose_ph    = photon_ok && tag_mode && !send_ph;
    wire logic       wr_valid   = send_mk || send_ovf || send_ph;
    // Absolute mode carries the raw 4 ps time field; sync-relative mode coarsens by the bin select
    wire logic [11:0] ph_time   = (MODE == TTGM_MODE_SYNC_REL_TAG) ? (PHOTON.dtime >> BIN_SEL) : PHOTON.dtime;
    wire logic [11:0] mk_time   = {9'h000, mk_all};
    wire ttgm_rec_t   mk_rec    = '{chan: CHAN_SPECIAL, dtime: mk_time, nsync: nsync_r};
    wire ttgm_rec_t   ovf_rec   = '{chan: CHAN_SPECIAL, dtime: TIME_OVERFLOW, nsync: nsync_r};
    wire ttgm_rec_t   ph_rec    = '{chan: PHOTON.chan, dtime: ph_time, nsync: nsync_r};
    wire ttgm_rec_t   wr_rec    = send_mk ? mk_rec : (send_ovf ? ovf_rec : ph_rec);
    // A 16-bit histogram index at 4..512 ps steps covers the full bin range
    wire logic [15:0] hist_idx  = 16'({PHOTON.chan, PHOTON.dtime} >> BIN_SEL);

    assign mk_pend_nxt = send_mk ? 3'h0 : mk_all;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            en_s1_r   <= 1'b1;
            en_s2_r   <= 1'b1;
            mk_s1_r   <= 3'h0;
            mk_s2_r   <= 3'h0;
            mk_s3_r   <= 3'h0;
            sync_s1_r <= 1'b0;
            sync_s2_r <= 1'b0;
            sync_s3_r <= 1'b0;
        end else if (CE) begin
            en_s1_r   <= COUNT_ENABLE;
            en_s2_r   <= en_s1_r;
            mk_s1_r   <= MARKER_IN;
            mk_s2_r   <= mk_s1_r;
            mk_s3_r   <= mk_s2_r;
            sync_s1_r <= SYNC_IN;
            sync_s2_r <= sync_s1_r;
            sync_s3_r <= sync_s2_r;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            active_r <= 1'b0;
        end else if (CE) begin
            if (MEAS_STOP) begin
                active_r <= 1'b0;
            end else if (MEAS_START) begin
                active_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            div_r   <= 3'h0;
            nsync_r <= NSYNC_RST;
        end else if (CE) begin
            // Idle clear obeys CE too, so a frozen block keeps its sync count
            if (!active_r) begin
                div_r   <= 3'h0;
                nsync_r <= NSYNC_RST;
            end else if (sync_edge) begin
                div_r <= div_r + 3'h1;
                if (sync_tick) begin
                    nsync_r <= nsync_r + 16'h0001;
                end
            end
        end
    end

    // Marker and overflow requests wait here while the FIFO is full, so none is lost
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mk_pend_r  <= 3'h0;
            ovf_pend_r <= 1'b0;
        end else if (CE) begin
            mk_pend_r <= mk_pend_nxt;
            if (send_ovf) begin
                ovf_pend_r <= 1'b0;
            end else if (nsync_wrap) begin
                ovf_pend_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            drop_r     <= 1'b0;
            hist_val_r <= 1'b0;
            hist_bin_r <= 16'h0000;
            bin_err_r  <= 1'b0;
        end else if (CE) begin
            drop_r     <= lose_ph;
            hist_val_r <= photon_ok && (MODE == TTGM_MODE_HIST);
            hist_bin_r <= hist_idx;
            bin_err_r  <= (BIN_SEL > BIN_SEL_MAX);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rec_val_r <= 1'b0;
            rec_r     <= '0;
        end else if (CE) begin
            if (!rec_val_r || REC_READY) begin
                rec_val_r <= out_valid;
                rec_r     <= out_data;
            end
        end
    end

    // Short staging FIFO; the deep record buffer lives behind REC_* downstream
    ttgm_fifo #(
        .WIDTH (REC_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst       (RST),
        .ce        (CE),
        .in_valid  (wr_valid),
        .in_ready  (fifo_ready),
        .in_data   (wr_rec),
        .out_valid (out_valid),
        .out_ready (!rec_val_r || REC_READY),
        .out_data  (out_data)
    );

    assign REC_VALID   = rec_val_r;
    assign REC_DATA    = rec_r;
    assign MEAS_ACTIVE = active_r;
    assign PHOTON_DROP = drop_r;
    assign HIST_VALID  = hist_val_r;
    assign HIST_BIN    = hist_bin_r;
    assign BIN_SEL_ERR = bin_err_r;
endmodule
`default_nettype wire

// File: verification/ttgm_scanner.sv
// Scanner model driving the count enable and marker pins
`timescale 1ns/1ps
`default_nettype none
module ttgm_scanner (
    input  wire logic       clk,
    input  wire logic       attached,
    input  wire logic       en_cmd,
    input  wire logic [2:0] mk_cmd,
    output logic            count_en,
    output logic [2:0]      markers
);
    // Open pins settle at the pad pulls: enable high, markers low
    always @(posedge clk) begin
        count_en <= attached ? en_cmd : 1'h1;
        markers <= attached ? mk_cmd : 3'h0;
    end
endmodule
`default_nettype wire

// File: verification/ttgm_top_asserts.sv
// Port-level assertions for the gating and marker block
`timescale 1ns/1ps
`default_nettype none
module ttgm_top_asserts (
    input wire logic                   CORE_CLK,
    input wire logic                   RST,
    input wire logic                   CE,
    input wire ttgm_pkg::ttgm_mode_t   MODE,
    input wire logic                   MEAS_START,
    input wire logic                   MEAS_STOP,
    input wire logic                   MARKER_FALLING,
    input wire logic [2:0]             MARKER_IN,
    input wire logic                   COUNT_ENABLE,
    input wire ttgm_pkg::ttgm_photon_t PHOTON,
    input wire logic                   REC_VALID,
    input wire logic                   REC_READY,
    input wire ttgm_pkg::ttgm_rec_t    REC_DATA,
    input wire logic                   MEAS_ACTIVE,
    input wire logic                   PHOTON_DROP,
    input wire logic                   HIST_VALID,
    input wire logic                   BIN_SEL_ERR
);
    import ttgm_pkg::*;
    default clocking dcb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence mk_rise_s;
        CE && REC_READY && MEAS_ACTIVE && MODE != TTGM_MODE_HIST && !MARKER_FALLING && $rose(MARKER_IN[0]);
    endsequence
    // Bound leaves room for a full FIFO ahead of the marker
    sequence mk_rec_s;
        ##[3:40] (REC_VALID && REC_DATA.chan == CHAN_SPECIAL && REC_DATA.dtime[0]);
    endsequence
    rec_hold_a: assert property (REC_VALID && !REC_READY |=> REC_VALID && $stable(REC_DATA))
        else $error("record changed before ready");
    drop_mode_a: assert property (PHOTON_DROP |-> $past(MODE) != TTGM_MODE_HIST)
        else $error("drop outside tag mode");
    hist_src_a: assert property (HIST_VALID |-> $past(PHOTON.valid) && $past(MEAS_ACTIVE))
        else $error("hit without photon");
    gate_off_a: assert property (!COUNT_ENABLE [*5] |=> !HIST_VALID)
        else $error("hit while gated");
    meas_on_a: assert property (MEAS_START && !MEAS_STOP && CE |=> MEAS_ACTIVE)
        else $error("start ignored");
    meas_off_a: assert property (MEAS_STOP && CE |=> !MEAS_ACTIVE)
        else $error("stop ignored");
    bin_err_a: assert property (!BIN_SEL_ERR)
        else $error("bin select error raised");
    marker_rec_a: assert property (mk_rise_s |-> mk_rec_s)
        else $error("marker record missing");
endmodule
bind ttgm_top ttgm_top_asserts u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .MODE(MODE),
    .MEAS_START(MEAS_START), .MEAS_STOP(MEAS_STOP), .MARKER_FALLING(MARKER_FALLING), .MARKER_IN(MARKER_IN),
    .COUNT_ENABLE(COUNT_ENABLE), .PHOTON(PHOTON), .REC_VALID(REC_VALID), .REC_READY(REC_READY),
    .REC_DATA(REC_DATA), .MEAS_ACTIVE(MEAS_ACTIVE), .PHOTON_DROP(PHOTON_DROP), .HIST_VALID(HIST_VALID),
    .BIN_SEL_ERR(BIN_SEL_ERR));
`default_nettype wire

// File: verification/ttgm_top_tb_top.sv
// Testbench for the gating and marker block
`timescale 1ns/1ps
`default_nettype none
module ttgm_top_tb_top;
    import ttgm_pkg::*;
    logic         clk = 1'h0;
    logic         rst = 1'h1;
    logic         meas_start = 1'h0;
    logic         meas_stop = 1'h0;
    logic         falling = 1'h0;
    logic [2:0]   bin_sel = 3'h2;
    logic         attached = 1'h1;
    logic         en_cmd = 1'h1;
    logic [2:0]   mk_cmd = 3'h0;
    logic         rec_ready = 1'h1;
    logic         ce = 1'h1;
    logic         sync_in = 1'h0;
    logic         sync_div = 1'h0;
    ttgm_mode_t   mode = TTGM_MODE_HIST;
    ttgm_photon_t photon = '0;
    logic         count_en, rec_valid, meas_active, photon_drop, hist_valid, bin_err;
    logic [2:0]   markers;
    logic [15:0]  hist_bin;
    ttgm_rec_t    rec_data, r;
    int           bad_count = 0;
    int           n_compared = 0;
    always #2 clk = ~clk;
    ttgm_scanner u_scan (.clk(clk), .attached(attached), .en_cmd(en_cmd), .mk_cmd(mk_cmd),
        .count_en(count_en), .markers(markers));
    ttgm_top dut (.CORE_CLK(clk), .RST(rst), .CE(ce), .MODE(mode), .MEAS_START(meas_start),
        .MEAS_STOP(meas_stop), .MARKER_FALLING(falling), .BIN_SEL(bin_sel), .SYNC_DIV_EN(sync_div),
        .SYNC_IN(sync_in), .COUNT_ENABLE(count_en), .MARKER_IN(markers), .PHOTON(photon),
        .REC_VALID(rec_valid), .REC_READY(rec_ready), .REC_DATA(rec_data), .MEAS_ACTIVE(meas_active),
        .PHOTON_DROP(photon_drop), .HIST_VALID(hist_valid), .HIST_BIN(hist_bin), .BIN_SEL_ERR(bin_err));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic shoot(input logic [3:0] ch, input logic [11:0] dt);
        photon = '{1'h1, ch, dt};
        step(1);
        photon.valid = 1'h0;
    endtask
    task automatic meas(input logic go);
        meas_start = go;
        meas_stop = !go;
        step(1);
        meas_start = 1'h0;
        meas_stop = 1'h0;
        step(1);
        chk("meas_active", 32'(meas_active), 32'(go));
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            chk("no_record", 32'(rec_valid), 32'h0);
            step(1);
        end
    endtask
    task automatic get_rec;
        logic got;
        got = 1'h0;
        for (int i = 0; i < 60 && !got; i++) begin
            got = (rec_valid === 1'h1);
            r = rec_data;
            step(1);
        end
        if (!got) begin
            chk("rec_timeout", 32'h0, 32'h1);
            complete_run();
        end
    endtask
    task automatic scan_hist(output int k, output logic [15:0] b);
        k = 0;
        b = 16'h0;
        repeat (4) begin
            if (hist_valid === 1'h1) begin
                k++;
                b = hist_bin;
            end
            step(1);
        end
    endtask
    task automatic t_hist;
        int k;
        logic [15:0] b;
        meas(1'h1);
        for (int s = 0; s < 8; s++) begin
            bin_sel = 3'(s);
            shoot(4'h3, 12'h5a8);
            scan_hist(k, b);
            chk("hist_hits", 32'(k), 32'h1);
            chk("hist_bin", 32'(b), 32'(16'h35a8 >> s));
            chk("bin_err", 32'(bin_err), 32'h0);
        end
        mk_cmd = 3'h7;
        quiet(8);
        mk_cmd = 3'h0;
        en_cmd = 1'h0;
        quiet(5);
        shoot(4'h3, 12'h5a8);
        scan_hist(k, b);
        chk("gated_hits", 32'(k), 32'h0);
        attached = 1'h0;
        step(4);
        shoot(4'h3, 12'h5a8);
        scan_hist(k, b);
        chk("open_hits", 32'(k), 32'h1);
        attached = 1'h1;
        en_cmd = 1'h1;
        meas(1'h0);
    endtask
    task automatic t_tag;
        bin_sel = 3'h2;
        for (int m = 1; m < 3; m++) begin
            mode = ttgm_mode_t'(m);
            meas(1'h1);
            shoot(4'h2, 12'h7f3);
            get_rec();
            chk("rec_chan", 32'(r.chan), 32'h2);
            if (m == 1) chk("abs_time", 32'(r.dtime), 32'h7f3);
            if (m == 1) meas(1'h0);
        end
        chk("rec_word", r, {4'h2, 12'h1fc, 16'h0});
        en_cmd = 1'h0;
        step(4);
        shoot(4'h2, 12'h7f3);
        quiet(8);
        en_cmd = 1'h1;
        step(4);
    endtask
    task automatic t_marker;
        mk_cmd = 3'h5;
        get_rec();
        chk("mk_rise", {r.chan, r.dtime}, {CHAN_SPECIAL, 12'h005});
        mk_cmd = 3'h0;
        quiet(8);
        falling = 1'h1;
        mk_cmd = 3'h2;
        quiet(8);
        mk_cmd = 3'h0;
        get_rec();
        chk("mk_fall", {r.chan, r.dtime}, {CHAN_SPECIAL, 12'h002});
        quiet(8);
        falling = 1'h0;
        attached = 1'h0;
        mk_cmd = 3'h7;
        quiet(8);
        attached = 1'h1;
        mk_cmd = 3'h0;
    endtask
    task automatic t_full;
        int n;
        logic drop, mk;
        n = 0;
        drop = 1'h0;
        mk = 1'h0;
        rec_ready = 1'h0;
        photon = '{1'h1, 4'h1, 12'h0};
        for (int i = 0; i < 24; i++) begin
            if (i == 10) mk_cmd = 3'h1;
            if (photon_drop === 1'h1) drop = 1'h1;
            photon.dtime = 12'(i);
            step(1);
        end
        photon.valid = 1'h0;
        mk_cmd = 3'h0;
        rec_ready = 1'h1;
        repeat (60) begin
            if (rec_valid === 1'h1) n++;
            if (rec_valid === 1'h1 && rec_data.chan === CHAN_SPECIAL) mk = 1'h1;
            step(1);
        end
        chk("drop_seen", 32'(drop), 32'h1);
        chk("marker_kept", 32'(mk), 32'h1);
        chk("drained", 32'(n >= FIFO_DEPTH), 32'h1);
    endtask
    task automatic pulse_sync(input int n);
        repeat (n) begin
            sync_in = 1'h1;
            step(2);
            sync_in = 1'h0;
            step(2);
        end
    endtask
    task automatic sync_rec(input logic [15:0] exp);
        shoot(4'h1, 12'h000);
        get_rec();
        chk("rec_nsync", 32'(r.nsync), 32'(exp));
    endtask
    task automatic t_sync;
        meas(1'h0);
        meas(1'h1);
        pulse_sync(3);
        sync_rec(16'h0003);
        sync_div = 1'h1;
        meas(1'h0);
        meas(1'h1);
        pulse_sync(SYNC_DIV - 1);
        sync_rec(16'h0000);
        pulse_sync(1);
        sync_rec(16'h0001);
        sync_div = 1'h0;
        ce = 1'h0;
        meas_stop = 1'h1;
        step(2);
        meas_stop = 1'h0;
        ce = 1'h1;
        chk("ce_freeze", 32'(meas_active), 32'h1);
        rst = 1'h1;
        step(2);
        chk("rst_active", 32'(meas_active), 32'h0);
        chk("rst_rec", 32'(rec_valid), 32'h0);
        rst = 1'h0;
        meas(1'h1);
    endtask
    task automatic complete_run;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        step(16);
        rst = 1'h0;
        t_hist();
        t_tag();
        t_marker();
        t_full();
        t_sync();
        complete_run();
    end
endmodule
`default_nettype wire
